/* File: hw/sffe_front_end.sv */
// Purpose: Device-side command front end of a serial NOR flash
// Assumes: Host drives cs_n and sclk; io lanes are synchronous to sclk
// Notes:   Array and status logic sit outside, on clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "sffe_map.svh"

module sffe_front_end
	import sffe_pkg::*;
#(
	parameter int BUF_W = 8,  // Buffer word width, one data byte
	parameter int BUF_D = 2   // Buffer depth in words
) (
	input  wire logic              clk_sys,    // System clock
	input  wire logic              rstn,       // Async reset, active low
	input  wire logic              sclk,       // Link clock from host
	input  wire logic              cs_n,       // Chip select, active low
	input  wire logic [3:0]        io_in,      // Lane inputs
	output logic      [3:0]        io_out,     // Lane outputs
	output logic      [3:0]        io_oe,      // Lane enables
	input  wire logic              busy_i,     // Program, erase, status write
	output logic                   rd_start,   // Read begins, one pulse
	output logic      [7:0]        rd_op,      // Read opcode
	output logic      [23:0]       rd_addr,    // Read start address
	input  wire logic [BUF_W-1:0]  arr_data,   // Read data byte
	input  wire logic              arr_valid,  // Read data offered
	output logic                   arr_ready,  // Buffer accepts data
	output logic                   wr_valid,   // Write command, one pulse
	output logic      [7:0]        wr_op,      // Write opcode
	output logic      [23:0]       wr_arg,     // Argument bytes, right aligned
	output logic      [2:0]        wr_nbytes,  // Argument byte count
	output logic                   qpi_mode,   // Four-line command mode
	output logic                   fast_mode   // Fast four-line read mode
);

	////////////////////////////////////////////////////////////////////////
	// Parameter checks

	// Only byte lanes and a power-of-two depth are served
	if (BUF_W != 8 || BUF_D < 2 || (BUF_D & (BUF_D - 1)) != 0) begin : g_chk
		$error("sffe_front_end: unsupported buffer shape");
	end

	localparam int PW = $clog2(BUF_D);     // Pointer width
	localparam int CW = $clog2(BUF_D + 1); // Fill count width

	// Sys-side state
	typedef struct packed {
		logic                         cs_s1;  // Chip select, first stage
		logic                         cs_s2;  // Chip select, second stage
		logic                         cs_s3;  // Edge history
		logic                         rq_s1;  // Request toggle, first stage
		logic                         rq_s2;  // Request toggle, second stage
		logic                         rq_s3;  // Edge history
		logic                         tk_s1;  // Take toggle, first stage
		logic                         tk_s2;  // Take toggle, second stage
		logic                         avail;  // Byte-ready toggle
		logic [7:0]                   hold;   // Byte offered to the link
		logic                         act;    // Read in progress
		logic                         rd_start;
		logic [7:0]                   rd_op;
		logic [23:0]                  rd_addr;
		logic                         wr_valid;
		logic [7:0]                   wr_op;
		logic [23:0]                  wr_arg;
		logic [2:0]                   wr_nbytes;
		logic [BUF_D-1:0][BUF_W-1:0]  mem;    // BUF_D-entry data buffer
		logic [PW-1:0]                wp;     // Write pointer
		logic [PW-1:0]                rp;     // Read pointer
		logic [CW-1:0]                cnt;    // Fill count
	} sffe_sys_t;

	////////////////////////////////////////////////////////////////////////
	// Opcode decoding

	// Opcode of a read-type instruction
	function automatic logic f_is_read(input logic [7:0] op);
		case (op)
			`SFFE_OP_READ, `SFFE_OP_FAST, `SFFE_OP_PTBL, `SFFE_OP_DUAL,
			`SFFE_OP_QRD_SHORT, `SFFE_OP_QRD, `SFFE_OP_ID,
			`SFFE_OP_STAT_RD, `SFFE_OP_SEC_RD, `SFFE_OP_EID,
			`SFFE_OP_MID: f_is_read = 1'b1;
			default:      f_is_read = 1'b0;
		endcase
	endfunction : f_is_read

	// Opcode of a write-type instruction
	function automatic logic f_is_write(input logic [7:0] op);
		case (op)
			`SFFE_OP_WEN, `SFFE_OP_WDIS, `SFFE_OP_STAT_WR, `SFFE_OP_QPROG,
			`SFFE_OP_SER, `SFFE_OP_BER32, `SFFE_OP_BER64, `SFFE_OP_CER_A,
			`SFFE_OP_CER_B, `SFFE_OP_PROG, `SFFE_OP_PDOWN, `SFFE_OP_SUSP,
			`SFFE_OP_RESUME, `SFFE_OP_OTP_IN, `SFFE_OP_OTP_OUT,
			`SFFE_OP_SEC_WR, `SFFE_OP_QPI_ON,
			`SFFE_OP_QPI_OFF: f_is_write = 1'b1;
			default:          f_is_write = 1'b0;
		endcase
	endfunction : f_is_write

	// Opcode that touches the memory array
	function automatic logic f_is_array(input logic [7:0] op);
		case (op)
			`SFFE_OP_READ, `SFFE_OP_FAST, `SFFE_OP_DUAL, `SFFE_OP_QRD_SHORT,
			`SFFE_OP_QRD, `SFFE_OP_QPROG, `SFFE_OP_SER, `SFFE_OP_BER32,
			`SFFE_OP_BER64, `SFFE_OP_CER_A, `SFFE_OP_CER_B,
			`SFFE_OP_PROG: f_is_array = 1'b1;
			default:       f_is_array = 1'b0;
		endcase
	endfunction : f_is_array

	// Read opcodes that go straight to data
	function automatic logic f_no_addr(input logic [7:0] op);
		f_no_addr = (op == `SFFE_OP_ID) || (op == `SFFE_OP_STAT_RD) ||
		            (op == `SFFE_OP_SEC_RD);
	endfunction : f_no_addr

	// Lanes used by address and data phases
	function automatic logic [2:0] f_lanes(input logic [7:0] op,
	                                       input logic four_line_command_mode);
		if (four_line_command_mode || op == `SFFE_OP_QRD || op == `SFFE_OP_QRD_SHORT) begin
			f_lanes = 3'h4;
		end else if (op == `SFFE_OP_DUAL) begin
			f_lanes = 3'h2;
		end else begin
			f_lanes = 3'h1;
		end
	endfunction : f_lanes

	// Dummy clocks after the address
	function automatic logic [3:0] f_dummy(input logic [7:0] op,
	                                       input logic four_line_command_mode, input logic fast);
		case (op)
			`SFFE_OP_FAST:      f_dummy = four_line_command_mode ? `SFFE_DUMMY_SHORT
			                                  : `SFFE_DUMMY_BYTE;
			`SFFE_OP_PTBL:      f_dummy = `SFFE_DUMMY_BYTE;
			`SFFE_OP_DUAL,
			`SFFE_OP_QRD_SHORT: f_dummy = `SFFE_DUMMY_SHORT;
			`SFFE_OP_QRD:       f_dummy = fast ? `SFFE_DUMMY_LONG
			                                   : `SFFE_DUMMY_SHORT;
			default:            f_dummy = `SFFE_DUMMY_NONE;
		endcase
	endfunction : f_dummy

	// Shift w lanes in at the bottom
	function automatic logic [23:0] f_shift(input logic [23:0] sh,
	                                        input logic [3:0] io,
	                                        input logic [2:0] w);
		case (w)
			3'h4:    f_shift = {sh[19:0], io};
			3'h2:    f_shift = {sh[21:0], io[1:0]};
			default: f_shift = {sh[22:0], io[0]};
		endcase
	endfunction : f_shift

	////////////////////////////////////////////////////////////////////////
	// Link domain

	logic       frame_rst_n; // Low outside a frame
	logic       fr_q;        // Frame has seen its first edge
	sffe_link_t l_q;         // Sequencer state
	sffe_link_t l_d;         // Its next value
	sffe_link_t base;        // State as seen by this edge
	sffe_pin_t  p_q;         // Pin drive state
	sffe_sys_t  s_q;         // Sys-side state
	sffe_sys_t  s_d;         // Its next value
	logic [2:0] w;           // Lanes sampled at this edge
	logic [2:0] dw;          // Lanes driven in data phase
	logic [7:0] byte_nx;     // Byte starting to go out
	logic       op_done;     // Opcode completes at this edge

	// A high chip select clears the frame flops; no edge is needed
	assign frame_rst_n = rstn & ~cs_n;

	// Frame start marker, set by the first rising edge
	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			fr_q <= 1'b0;
		end else begin
			fr_q <= 1'b1;
		end
	end

	// Command sequencer; only edges are used, so idle level is free
	always_comb begin
		base    = l_q;
		op_done = 1'b0;
		byte_nx = `SFFE_FILL_BYTE;
		// First edge of a frame: fresh decoder, pending mode switch
		if (!fr_q) begin
			if (l_q.st == L_WARG && l_q.nbits == 6'h00) begin
				if (l_q.op == `SFFE_OP_QPI_ON) begin
					base.four_line_command_mode = 1'b1;
				end
				if (l_q.op == `SFFE_OP_QPI_OFF) begin
					base.four_line_command_mode = 1'b0;
				end
			end
			base.st    = L_CMD;
			base.nbits = 6'h00;
			base.sh    = 24'h000000;
		end
		// Four-line mode carries opcode and address on four lanes
		if (base.st == L_ADDR) begin
			w = f_lanes(base.op, base.four_line_command_mode);
		end else begin
			w = base.four_line_command_mode ? 3'h4 : 3'h1;
		end
		dw       = f_lanes(base.op, base.four_line_command_mode);
		l_d      = base;
		l_d.av_s1 = s_q.avail;
		l_d.av_s2 = l_q.av_s1;
		// Bits are taken on the rising edge only
		case (base.st)
			L_CMD: begin
				l_d.sh    = f_shift(base.sh, io_in, w);
				l_d.nbits = base.nbits + {3'h0, w};
				if (l_d.nbits == `SFFE_OP_BITS) begin
					op_done   = 1'b1;
					l_d.op    = l_d.sh[7:0];
					l_d.nbits = 6'h00;
					if (f_is_read(l_d.op)) begin
						if (l_d.op == `SFFE_OP_QRD) begin
							l_d.fast = 1'b1;
						end
						if (f_no_addr(l_d.op)) begin
							l_d.addr     = 24'h000000;
							l_d.req_tgl  = ~base.req_tgl;
							l_d.take_tgl = base.av_s2;
							l_d.orem     = 4'h0;
							l_d.st       = L_DATA;
						end else begin
							l_d.st = L_ADDR;
						end
					end else if (f_is_write(l_d.op)) begin
						l_d.sh = 24'h000000;
						l_d.st = L_WARG;
					end else begin
						l_d.st = L_STBY;
					end
				end
			end
			L_ADDR: begin
				l_d.sh    = f_shift(base.sh, io_in, w);
				l_d.nbits = base.nbits + {3'h0, w};
				if (l_d.nbits == `SFFE_ADDR_BITS) begin
					// First byte in ends up on top
					l_d.addr     = l_d.sh;
					l_d.req_tgl  = ~base.req_tgl;
					l_d.take_tgl = base.av_s2; // Drops stale bytes
					l_d.nbits    = 6'h00;
					l_d.dcnt     = 4'h0;
					l_d.orem     = 4'h0;
					if (f_dummy(base.op, base.four_line_command_mode, base.fast) == 4'h0) begin
						l_d.st = L_DATA;
					end else begin
						l_d.st = L_DUMMY;
					end
				end
			end
			L_DUMMY: begin
				l_d.dcnt = base.dcnt + 4'h1;
				if (l_d.dcnt == f_dummy(base.op, base.four_line_command_mode, base.fast)) begin
					l_d.st = L_DATA;
				end
			end
			L_WARG: begin
				// Argument bits; the count tells the boundary later
				l_d.sh = f_shift(base.sh, io_in, w);
				if (base.nbits < 6'h38) begin
					l_d.nbits = base.nbits + {3'h0, w};
				end else begin
					// Count saturates; low bits still track the boundary
					l_d.nbits[2:0] = base.nbits[2:0] + w;
				end
			end
			L_DATA, L_STBY: begin
				// Input ignored; standby waits for the next frame
			end
			default: l_d.st = L_STBY;
		endcase
		// Next output lanes; a byte not yet delivered goes out as fill
		l_d.doe  = 4'h0;
		l_d.dnib = 4'h0;
		if (l_d.st == L_DATA) begin
			if (l_d.orem == 4'h0) begin
				if (l_q.av_s2 != l_d.take_tgl) begin
					byte_nx      = s_q.hold; // Stable until take returns
					l_d.take_tgl = ~l_d.take_tgl;
				end
			end else begin
				byte_nx = l_d.ob;
			end
			case (dw)
				3'h4: begin
					l_d.dnib = byte_nx[7:4];
					l_d.doe  = 4'hF;
				end
				3'h2: begin
					l_d.dnib = {2'h0, byte_nx[7:6]};
					l_d.doe  = 4'h3;
				end
				default: begin
					l_d.dnib = {2'h0, byte_nx[7], 1'b0};
					l_d.doe  = 4'h2;
				end
			endcase
			l_d.ob   = byte_nx << dw;
			// A fresh byte starts at eight bits less one lane group, else one lane group less
			if (l_d.orem == 4'h0) begin
				l_d.orem = 4'h8 - {1'b0, dw};
			end else begin
				l_d.orem = l_d.orem - {1'b0, dw};
			end
		end
	end

	// Sequencer register; modes survive frames, so only rstn clears it
	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			l_q <= '{st: L_STBY, default: '0};
		end else begin
			l_q <= l_d;
		end
	end

	// Lanes change on the falling edge; cs high floats them at once
	always_ff @(negedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			p_q <= '0;
		end else begin
			p_q <= '{out: l_q.dnib, oe: l_q.doe};
		end
	end

	assign io_out    = p_q.out;
	assign io_oe     = p_q.oe;
	assign qpi_mode  = l_q.four_line_command_mode;
	assign fast_mode = l_q.fast;

	////////////////////////////////////////////////////////////////////////
	// System domain

	// Request, flush, buffer and write hand-off on clk_sys
	always_comb begin
		s_d          = s_q;
		s_d.cs_s1    = cs_n;
		s_d.cs_s2    = s_q.cs_s1;
		s_d.cs_s3    = s_q.cs_s2;
		s_d.rq_s1    = l_q.req_tgl;
		s_d.rq_s2    = s_q.rq_s1;
		s_d.rq_s3    = s_q.rq_s2;
		s_d.tk_s1    = l_q.take_tgl;
		s_d.tk_s2    = s_q.tk_s1;
		s_d.rd_start = 1'b0;
		s_d.wr_valid = 1'b0;
		// Hand the next byte over once the last one was taken
		if (s_q.act && s_q.avail == s_q.tk_s2 && s_q.cnt != '0) begin
			s_d.hold  = s_q.mem[s_q.rp];
			s_d.avail = ~s_q.avail;
			s_d.rp    = s_q.rp + 1'b1;
			s_d.cnt   = s_d.cnt - 1'b1;
		end
		// Sequential bytes arrive from the array side
		if (arr_valid && arr_ready) begin
			s_d.mem[s_q.wp] = arr_data;
			s_d.wp          = s_q.wp + 1'b1;
			s_d.cnt         = s_d.cnt + 1'b1;
		end
		// Link stable: op and address were set with the toggle
		if (s_q.rq_s2 != s_q.rq_s3) begin
			s_d.rd_op   = l_q.op;
			s_d.rd_addr = l_q.addr;
			s_d.cnt     = '0;
			s_d.wp      = '0;
			s_d.rp      = '0;
			s_d.act     = 1'b0;
			if (!(busy_i && f_is_array(l_q.op))) begin
				s_d.rd_start = 1'b1;
				s_d.act      = 1'b1;
			end
		end
		// Frame end: sclk has stopped, link state is static
		if (s_q.cs_s2 && !s_q.cs_s3) begin
			s_d.act = 1'b0;
			s_d.cnt = '0;
			s_d.wp  = '0;
			s_d.rp  = '0;
			if (l_q.st == L_WARG && l_q.nbits[2:0] == 3'h0 &&
			    !(busy_i && f_is_array(l_q.op))) begin
				s_d.wr_valid  = 1'b1;
				s_d.wr_op     = l_q.op;
				s_d.wr_arg    = l_q.sh;
				s_d.wr_nbytes = l_q.nbits[5:3];
			end
		end
	end

	// Sys register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_q <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// Ready stalls the array side when all BUF_D entries are full
	assign arr_ready = s_q.act && (s_q.cnt < CW'(BUF_D));
	assign rd_start  = s_q.rd_start;
	assign rd_op     = s_q.rd_op;
	assign rd_addr   = s_q.rd_addr;
	assign wr_valid  = s_q.wr_valid;
	assign wr_op     = s_q.wr_op;
	assign wr_arg    = s_q.wr_arg;
	assign wr_nbytes = s_q.wr_nbytes;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	a_unknown_goes_stby: assert property (
		@(posedge sclk) disable iff (!rstn)
		op_done && !f_is_read(l_d.op) && !f_is_write(l_d.op)
		|=> l_q.st == L_STBY ##1 l_q.st == L_STBY || !fr_q
	) else $error("unknown opcode did not enter standby");

	a_stby_floats: assert property (
		@(posedge sclk) disable iff (!rstn)
		fr_q && l_q.st == L_STBY |-> io_oe == 4'h0
	) else $error("lanes driven in standby");

	a_known_active: assert property (
		@(posedge sclk) disable iff (!rstn)
		op_done && f_is_read(l_d.op) |=> l_q.st != L_STBY
	) else $error("known opcode not active");

	a_frame_restart: assert property (
		@(posedge sclk) disable iff (!rstn)
		!fr_q && !cs_n |=> l_q.st == L_CMD &&
		l_q.nbits == (l_q.four_line_command_mode ? 6'h04 : 6'h01)
	) else $error("decoder not restarted at frame start");

	a_qpi_enter: assert property (
		@(posedge sclk) disable iff (!rstn)
		!fr_q && l_q.st == L_WARG && l_q.nbits == 6'h00 &&
		l_q.op == 8'h35 |=> l_q.four_line_command_mode
	) else $error("35h did not enter four-line mode");

	a_qpi_leave: assert property (
		@(posedge sclk) disable iff (!rstn)
		!fr_q && l_q.st == L_WARG && l_q.nbits == 6'h00 &&
		l_q.op == 8'hF5 |=> !l_q.four_line_command_mode
	) else $error("F5h did not leave four-line mode");

	a_eb_six_dummy: assert property (
		@(posedge sclk) disable iff (!rstn || cs_n)
		l_q.st == L_ADDR && l_d.st == L_DUMMY && l_q.op == 8'hEB
		|=> (l_q.st == L_DUMMY)[*6] ##1 l_q.st == L_DATA
	) else $error("EBh dummy phase not six clocks");

	a_eb_addr_quad: assert property (
		@(posedge sclk) disable iff (!rstn)
		l_q.st == L_CMD && l_d.st == L_ADDR && l_d.op == 8'hEB
		|=> (l_q.st == L_ADDR)[*6] ##1 l_q.st != L_ADDR
	) else $error("EBh address not six quad clocks");

	a_qpi_four_lanes: assert property (
		@(posedge sclk) disable iff (!rstn)
		l_q.four_line_command_mode && l_q.st == L_DATA && io_oe != 4'h0 |-> io_oe == 4'hF
	) else $error("four-line mode drove fewer lanes");

	a_wr_on_boundary: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		wr_valid |-> $past(l_q.nbits[2:0]) == 3'h0 && !s_q.cs_s3 == 1'b0
	) else $error("write accepted off a byte boundary");

	a_busy_blocks: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		rd_start |-> !($past(busy_i) && f_is_array(rd_op))
	) else $error("array read launched while busy");

	a_addr_handoff: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		rd_start |-> rd_addr == l_q.addr && rd_op == l_q.op
	) else $error("read address not handed over");

	c_qpi_entry: cover property (
		@(posedge sclk) disable iff (!rstn) $rose(l_q.four_line_command_mode));
	c_eb_data: cover property (
		@(posedge sclk) disable iff (!rstn)
		l_q.op == 8'hEB && l_q.st == L_DATA && io_oe == 4'hF);
	c_standby: cover property (
		@(posedge sclk) disable iff (!rstn) $rose(l_q.st == L_STBY));
	c_write_cmd: cover property (
		@(posedge clk_sys) disable iff (!rstn) wr_valid);
	c_buf_full: cover property (
		@(posedge clk_sys) disable iff (!rstn) arr_valid && !arr_ready);

endmodule : sffe_front_end
`default_nettype wire

/* File: shared/sffe_map.svh */
// Purpose: Opcodes, bit counts and dummy counts of the command front end
// Assumes: Included by the front end only, by bare name
// Notes:   Definitions only
`ifndef SFFE_MAP_SVH
`define SFFE_MAP_SVH

// Read-type opcodes
`define SFFE_OP_READ      8'h03
`define SFFE_OP_FAST      8'h0B
`define SFFE_OP_PTBL      8'h5A
`define SFFE_OP_DUAL      8'hBB
`define SFFE_OP_QRD_SHORT 8'hE7
`define SFFE_OP_QRD       8'hEB
`define SFFE_OP_ID        8'h9F
`define SFFE_OP_STAT_RD   8'h05
`define SFFE_OP_SEC_RD    8'h2B
`define SFFE_OP_EID       8'hAB
`define SFFE_OP_MID       8'h90

// Write-type opcodes
`define SFFE_OP_WEN       8'h06
`define SFFE_OP_WDIS      8'h04
`define SFFE_OP_STAT_WR   8'h01
`define SFFE_OP_QPROG     8'h38
`define SFFE_OP_SER       8'h20
`define SFFE_OP_BER32     8'h52
`define SFFE_OP_BER64     8'hD8
`define SFFE_OP_CER_A     8'h60
`define SFFE_OP_CER_B     8'hC7
`define SFFE_OP_PROG      8'h02
`define SFFE_OP_PDOWN     8'hB9
`define SFFE_OP_SUSP      8'hB0
`define SFFE_OP_RESUME    8'h30
`define SFFE_OP_OTP_IN    8'hB1
`define SFFE_OP_OTP_OUT   8'hC1
`define SFFE_OP_SEC_WR    8'h2F
`define SFFE_OP_QPI_ON    8'h35
`define SFFE_OP_QPI_OFF   8'hF5

// Dummy clocks between address and data
`define SFFE_DUMMY_NONE   4'h0
`define SFFE_DUMMY_SHORT  4'h4
`define SFFE_DUMMY_LONG   4'h6
`define SFFE_DUMMY_BYTE   4'h8

// Bits in an opcode and in an address, and the fill byte
`define SFFE_OP_BITS      6'h08
`define SFFE_ADDR_BITS    6'h18
`define SFFE_FILL_BYTE    8'hFF

`endif

/* File: shared/sffe_pkg.sv */
// Purpose: Types of the serial flash command front end
// Assumes: Nothing beyond the map header
// Notes:   Sys-side state depends on buffer parameters and lives in the module
`default_nettype none
package sffe_pkg;

	// Link-side command sequencer
	typedef enum logic [2:0] {
		L_CMD, L_ADDR, L_DUMMY, L_DATA, L_WARG, L_STBY
	} sffe_lst_t;

	// Link-side state, clocked on rising serial clock
	typedef struct packed {
		sffe_lst_t   st;       // Sequencer state
		logic [5:0]  nbits;    // Bits taken in the current phase
		logic [23:0] sh;       // Incoming shift register
		logic [7:0]  op;       // Latched opcode
		logic [23:0] addr;     // Latched address
		logic [3:0]  dcnt;     // Dummy clocks seen
		logic        four_line_command_mode;      // Four-line command mode
		logic        fast;     // Fast four-line read mode
		logic        req_tgl;  // Read request event toward sys
		logic        take_tgl; // Byte taken event toward sys
		logic        av_s1;    // Byte-ready toggle, first stage
		logic        av_s2;    // Byte-ready toggle, second stage
		logic [7:0]  ob;       // Outgoing byte remainder
		logic [3:0]  orem;     // Outgoing bits left
		logic [3:0]  dnib;     // Lanes to drive at the next fall
		logic [3:0]  doe;      // Lane enables for the next fall
	} sffe_link_t;

	// Pin drive state, clocked on falling serial clock
	typedef struct packed {
		logic [3:0] out;       // Driven lane values
		logic [3:0] oe;        // Lane enables
	} sffe_pin_t;

endpackage : sffe_pkg
`default_nettype wire

/* File: verification/sffe_host.sv */
// Purpose: Host controller model driving the serial command link
// Assumes: The bench calls frame() and judges what it returns
// Notes:   Released lanes carry the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module sffe_host (
	output logic            cs_n,   // Chip select, active low
	output logic            sclk,   // Link clock, still between frames
	output logic      [3:0] io_in,  // Lanes toward the device
	input  wire logic [3:0] io_out, // Lanes from the device
	input  wire logic [3:0] io_oe   // Device lane enables
);
	logic oe_any; // Device drove a lane during the frame
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		io_in = 4'hA;
		oe_any = 1'b0;
	end
	// Any lane enable raised; cleared at frame start
	always @(io_oe) if (io_oe !== 4'h0) oe_any = 1'b1;
	////////////////////////////////////////////////////////////////////
	// One frame: w left aligned, nb bits on ln lanes, rd read clocks
	task automatic frame(input logic [31:0] w, input int nb, input int ln,
		input int rd, input bit m3, output logic [7:0] got);
		logic [31:0] s;
		s = w;
		got = 8'h00;
		sclk = m3;
		#10;
		oe_any = 1'b0;
		cs_n = 1'b0;
		#6;
		for (int i = 0; i < nb / ln + rd; i++) begin
			sclk = 1'b0;
			if (i >= nb / ln) io_in = ~io_in;
			else if (ln == 4) io_in = s[31:28];
			else io_in = {~io_in[3:1], s[31]};
			s = s << ln;
			#6;
			// About 83 MHz, so the slower read limit always holds
			sclk = 1'b1;
			// A released lane reads back as the inverse of the last bit
			got = {got[6:0], io_oe[1] ? io_out[1] : ~got[0]};
			#6;
		end
		sclk = m3;
		#6;
		cs_n = 1'b1;
		io_in = ~io_in;
		#6;
	endtask : frame
endmodule : sffe_host
`default_nettype wire

/* File: verification/serial_flash_command_front_end_tb.sv */
// Purpose: Self-checking bench of the serial command front end
// Assumes: Host model drives the link; bench drives the sys side
// Notes:   Read data stalls every other cycle so the buffer fills
`timescale 1ns/1ps
`default_nettype none
module serial_flash_command_front_end_tb;
	logic        clk_sys, rstn, busy_i, arr_valid, arr_ready, took;
	logic        cs_n, sclk, rd_start, wr_valid, qpi_mode, fast_mode;
	logic [7:0]  arr_data, rd_op, wr_op, b;
	logic [23:0] rd_addr, wr_arg;
	logic [3:0]  io_in, io_out, io_oe;
	logic [2:0]  wr_nbytes;
	int          err_count, tests_run, rd_n, wr_n, n;
	sffe_host host_u (.cs_n(cs_n), .sclk(sclk), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe));
	sffe_front_end #(.BUF_W(8), .BUF_D(2)) dut_u (.clk_sys(clk_sys),
		.rstn(rstn), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe), .busy_i(busy_i),
		.rd_start(rd_start), .rd_op(rd_op), .rd_addr(rd_addr),
		.arr_data(arr_data), .arr_valid(arr_valid), .arr_ready(arr_ready),
		.wr_valid(wr_valid), .wr_op(wr_op), .wr_arg(wr_arg),
		.wr_nbytes(wr_nbytes), .qpi_mode(qpi_mode), .fast_mode(fast_mode));
	// System clock, 20 ns
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// Pulses counted where they have settled, off the launching edge
	always @(negedge clk_sys) begin
		if (rd_start === 1'b1) rd_n++;
		if (wr_valid === 1'b1) wr_n++;
	end
	// Data source: idle a cycle after each take, held while refused
	always @(posedge clk_sys) took <= arr_valid & arr_ready;
	always @(negedge clk_sys) arr_valid <= rstn & (~arr_valid | ~took);
	////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// Frame, then room for the sys-side pulse to land
	task automatic fr(input logic [31:0] w, input int nb, input int ln,
		input int rd, input bit m3);
		host_u.frame(w, nb, ln, rd, m3, b);
		repeat (8) @(negedge clk_sys);
	endtask : fr
	task automatic t_unknown();
		n = rd_n;
		fr(32'h00000000, 8, 1, 16, 1'b0);
		chk("oe_any", 0, host_u.oe_any);
		chk("rd_n", n, rd_n);
	endtask : t_unknown
	task automatic t_read();
		n = rd_n;
		fr(32'h0312345A, 32, 1, 32, 1'b0);
		chk("rd_n", n + 1, rd_n);
		chk("rd_op", 8'h03, rd_op);
		chk("rd_addr", 24'h12345A, rd_addr);
		chk("byte", 8'h3C, b);
		chk("oe_any", 1, host_u.oe_any);
		chk("arr_ready", 0, arr_ready);
	endtask : t_read
	task automatic t_write();
		n = wr_n;
		fr(32'h06000000, 8, 1, 0, 1'b1);
		chk("wr_op", 8'h06, wr_op);
		chk("wr_nb", 0, wr_nbytes);
		fr(32'h20ABCDEF, 32, 1, 0, 1'b0);
		chk("wr_arg", 24'hABCDEF, wr_arg);
		chk("wr_nb", 3, wr_nbytes);
		fr(32'h06000000, 9, 1, 0, 1'b0);
		chk("wr_n", n + 2, wr_n);
	endtask : t_write
	task automatic t_busy();
		busy_i = 1'b1;
		n = rd_n;
		fr(32'h05000000, 8, 1, 16, 1'b0);
		chk("rd_n", n + 1, rd_n);
		chk("rd_op", 8'h05, rd_op);
		n = rd_n;
		fr(32'h03000100, 32, 1, 13, 1'b0);
		chk("rd_n", n, rd_n);
		chk("oe_off", 0, io_oe);
		n = wr_n;
		fr(32'h20000100, 32, 1, 0, 1'b0);
		chk("wr_n", n, wr_n);
		busy_i = 1'b0;
	endtask : t_busy
	task automatic t_quad();
		fr(32'h35000000, 8, 1, 0, 1'b0);
		n = wr_n;
		fr(32'h06000000, 8, 4, 0, 1'b0);
		chk("wr_n", n + 1, wr_n);
		chk("qpi", 1, qpi_mode);
		fr(32'hEB00C0DE, 32, 4, 14, 1'b0);
		chk("rd_addr", 24'h00C0DE, rd_addr);
		chk("fast", 1, fast_mode);
		fr(32'hF5000000, 8, 4, 0, 1'b0);
		n = wr_n;
		fr(32'h06000000, 8, 1, 0, 1'b0);
		chk("wr_n", n + 1, wr_n);
		chk("qpi", 0, qpi_mode);
	endtask : t_quad
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	// Watchdog, well past the expected run length
	initial begin
		#100000;
		err_count++;
		wrap_up();
	end
	// Main sequence
	initial begin
		rstn = 1'b0;
		busy_i = 1'b0;
		arr_data = 8'h3C;
		repeat (5) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (3) @(negedge clk_sys);
		t_unknown();
		t_read();
		t_write();
		t_busy();
		t_quad();
		wrap_up();
	end
endmodule : serial_flash_command_front_end_tb
`default_nettype wire
